// ### verilog/tmc_pkg.sv
/*
 tmc_pkg: special function register addresses, field positions,
 reset values, divider constants, mode enum and carrier structs for
 the three-channel timer/counter.
 assumes: a byte-wide special function register port from the core.
*/
package tmc_pkg;

   // special function register addresses
   localparam logic [7:0] TMC_ADDR_RUN_CTRL  = 8'h88;
   localparam logic [7:0] TMC_ADDR_MODE      = 8'h89;
   localparam logic [7:0] TMC_ADDR_CNT_LO0   = 8'h8A;
   localparam logic [7:0] TMC_ADDR_CNT_LO1   = 8'h8B;
   localparam logic [7:0] TMC_ADDR_CNT_HI0   = 8'h8C;
   localparam logic [7:0] TMC_ADDR_CNT_HI1   = 8'h8D;
   localparam logic [7:0] TMC_ADDR_CLK_DIV   = 8'h8E;
   localparam logic [7:0] TMC_ADDR_T2_CTRL   = 8'hC8;
   localparam logic [7:0] TMC_ADDR_CNT_LO2   = 8'hCC;
   localparam logic [7:0] TMC_ADDR_CNT_HI2   = 8'hCD;

   // reset values
   localparam logic [7:0] TMC_RST_MODE       = 8'h00;
   localparam logic [7:0] TMC_RST_RUN_CTRL   = 8'h00;
   localparam logic [7:0] TMC_RST_CLK_DIV    = 8'h01;
   localparam logic [7:0] TMC_RST_T2_CTRL    = 8'h00;
   localparam logic [7:0] TMC_RST_CNT        = 8'h00;
   localparam logic [7:0] TMC_UNMAPPED_READ  = 8'h00;

   // timer_mode_select fields
   localparam int TMC_GATE1     = 7;
   localparam int TMC_CT1       = 6;
   localparam int TMC_MODE1_HI  = 5;
   localparam int TMC_MODE1_LO  = 4;
   localparam int TMC_GATE0     = 3;
   localparam int TMC_CT0       = 2;
   localparam int TMC_MODE0_HI  = 1;
   localparam int TMC_MODE0_LO  = 0;

   // timer_run_control_reg fields
   localparam int TMC_OVF1      = 7;
   localparam int TMC_RUN1      = 6;
   localparam int TMC_OVF0      = 5;
   localparam int TMC_RUN0      = 4;

   // clock_divide_control_reg fields
   localparam int TMC_DIVSEL1   = 4;
   localparam int TMC_DIVSEL0   = 3;

   // timer two control fields
   localparam int TMC_OVF2      = 7;
   localparam int TMC_RUN2      = 2;
   localparam int TMC_CT2       = 1;

   // cpu clock divider
   localparam int         TMC_DIV_FAST   = 4;
   localparam int         TMC_DIV_SLOW   = 12;
   localparam logic [3:0] TMC_PRE_LAST   = 4'(TMC_DIV_SLOW - 1);
   localparam logic [1:0] TMC_FAST_LAST  = 2'(TMC_DIV_FAST - 1);

   // synchroniser pin positions
   localparam int TMC_PIN_EV0   = 0;
   localparam int TMC_PIN_EV1   = 1;
   localparam int TMC_PIN_EV2   = 2;
   localparam int TMC_PIN_IRQ0  = 3;
   localparam int TMC_PIN_IRQ1  = 4;
   localparam int TMC_NUM_PINS  = 5;

   typedef enum logic [1:0] {
      TMC_M13,
      TMC_M16,
      TMC_M8R,
      TMC_MSPLIT
   } tmc_mode_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmc_sfr_req_s;

   typedef struct packed {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } tmc_cnt_s;

endpackage : tmc_pkg

// ### verilog/tmc_timer_counter.sv
/*
 tmc_timer_counter: timers zero, one and two with mode decode, gate,
 clock select, cpu clock divider and their special function registers.
 assumes: pins and sfr requests synchronous to clock; the core pulses
 an isr acknowledge when it vectors to a timer interrupt.
*/
`timescale 1ns/1ps

// Overview of operation
// - three timer/counters, cpu clock or event pin
// - event inputs on p0.5, p0.6, p1.0
// - 16-bit count as low and high bytes
// - four modes, run bits start and stop
// - mode field 00 13b,01 16b,10 reload,11 split
// - split mode only on timer zero
// - timer one gate needs pin high and run
// - timer one clock: divided cpu or pin
// - bits 5:4 are timer one mode
// - timer zero gate needs pin high and run
// - timer zero clock: divided cpu or pin
// - bits 1:0 are timer zero mode
// - 13-bit rollover sets flag, one-clock pulse
// - flag set on overflow, timer zero and one flags cleared on vector
module tmc_timer_counter
   import tmc_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // special function register port
   input  wire tmc_sfr_req_s sfr_req,
   output logic [7:0]        sfr_rdata,
   // pins: p0.5, p0.6, p1.0 and external interrupts
   input  wire logic         event_input_zero,
   input  wire logic         event_input_one,
   input  wire logic         event_input_two,
   input  wire logic         ext_irq_pin_zero_low,
   input  wire logic         ext_irq_pin_one_low,
   // interrupt vector acknowledges
   input  wire logic         isr_ack_zero,
   input  wire logic         isr_ack_one,
   // timer outputs and flags
   output logic              timer_out_zero,
   output logic              timer_out_one,
   output logic              overflow_flag_zero,
   output logic              overflow_flag_one,
   output logic              overflow_flag_two
);

   function automatic tmc_cnt_s tmc_step(input tmc_mode_e m,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
      tmc_cnt_s    r;
      logic [8:0]  s9;
      logic [13:0] s13;
      logic [16:0] s17;
      r   = '{ovf: 1'b0, hi: hi, lo: lo};
      s9  = {1'b0, lo} + 9'h001;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s17 = {1'b0, hi, lo} + 17'h0_0001;
      unique case (m)
         TMC_M13:
         begin
            r.ovf = s13[13];
            r.hi  = s13[12:5];
            r.lo  = {lo[7:5], s13[4:0]};
         end
         TMC_M16:
         begin
            r.ovf = s17[16];
            r.hi  = s17[15:8];
            r.lo  = s17[7:0];
         end
         TMC_M8R:
         begin
            r.ovf = s9[8];
            r.lo  = s9[8] ? hi : s9[7:0];
         end
         TMC_MSPLIT:
         begin
            r.ovf = s9[8];
            r.lo  = s9[7:0];
         end
      endcase
      return r;
   endfunction : tmc_step

   logic [TMC_NUM_PINS-1:0] pins_meta_q;
   logic [TMC_NUM_PINS-1:0] pins_sync_q;
   logic [2:0]              pins_prev_q;
   logic [TMC_NUM_PINS-1:0] pins_raw;
   logic [7:0]              mode_q, mode_d;
   logic [7:0]              rc_q, rc_d;
   logic [7:0]              ckdiv_q, ckdiv_d;
   logic [7:0]              t2c_q, t2c_d;
   logic [7:0]              lo0_q, lo0_d, hi0_q, hi0_d;
   logic [7:0]              lo1_q, lo1_d, hi1_q, hi1_d;
   logic [7:0]              lo2_q, lo2_d, hi2_q, hi2_d;
   logic [3:0]              pre_q, pre_d;
   logic                    out0_q, out0_d, out1_q, out1_d;
   logic [7:0]              rdata_q, rdata_d;
   logic                    tick_fast, tick_slow, div0, div1;
   logic [2:0]              ev_fall;
   tmc_mode_e               m0, m1;
   logic                    tick0, tick1, tick2, en0, en1;
   logic                    cnt0, cnt1, cnt2, split, inc_th0;
   logic                    set0, set1, set2, wr;
   tmc_cnt_s                st0, st1;
   logic [8:0]              hi0_inc;
   logic [16:0]             s2;

   // event pins are port alternate functions
   assign pins_raw = {ext_irq_pin_one_low, ext_irq_pin_zero_low,
                      event_input_two, event_input_one,
                      event_input_zero};

   always_comb
   begin
      // cpu clock divider, /4 and /12 enables
      tick_fast = (pre_q[1:0] == TMC_FAST_LAST);
      tick_slow = (pre_q == TMC_PRE_LAST);
      pre_d     = tick_slow ? 4'h0 : pre_q + 4'h1;
      ev_fall   = pins_prev_q & ~pins_sync_q[2:0];
      m0 = tmc_mode_e'(mode_q[TMC_MODE0_HI:TMC_MODE0_LO]);
      m1 = tmc_mode_e'(mode_q[TMC_MODE1_HI:TMC_MODE1_LO]);
      div0 = ckdiv_q[TMC_DIVSEL0] ? tick_fast : tick_slow;
      div1 = ckdiv_q[TMC_DIVSEL1] ? tick_fast : tick_slow;
      tick0 = mode_q[TMC_CT0] ? ev_fall[TMC_PIN_EV0] : div0;
      tick1 = mode_q[TMC_CT1] ? ev_fall[TMC_PIN_EV1] : div1;
      en0 = rc_q[TMC_RUN0] &
            (~mode_q[TMC_GATE0] | pins_sync_q[TMC_PIN_IRQ0]);
      en1 = rc_q[TMC_RUN1] &
            (~mode_q[TMC_GATE1] | pins_sync_q[TMC_PIN_IRQ1]);
      st0     = tmc_step(m0, lo0_q, hi0_q);
      st1     = tmc_step(m1, lo1_q, hi1_q);
      split   = (m0 == TMC_MSPLIT);
      // run bits start and stop counting
      cnt0    = tick0 & en0;
      hi0_inc = {1'b0, hi0_q} + 9'h001;
      inc_th0 = split & rc_q[TMC_RUN1] & div1;
      // timer one holds in split mode
      cnt1    = tick1 & en1 & (m1 != TMC_MSPLIT);
      // timer two as timer or event counter
      tick2   = t2c_q[TMC_CT2] ? ev_fall[TMC_PIN_EV2] : tick_slow;
      cnt2    = tick2 & t2c_q[TMC_RUN2];
      s2      = {1'b0, hi2_q, lo2_q} + 17'h0_0001;
      set0    = cnt0 & st0.ovf;
      set1    = (inc_th0 & hi0_inc[8]) | (cnt1 & st1.ovf & ~split);
      set2    = cnt2 & s2[16];
      lo0_d   = cnt0 ? st0.lo : lo0_q;
      hi0_d   = split ? (inc_th0 ? hi0_inc[7:0] : hi0_q)
                      : (cnt0 ? st0.hi : hi0_q);
      lo1_d   = cnt1 ? st1.lo : lo1_q;
      hi1_d   = cnt1 ? st1.hi : hi1_q;
      lo2_d   = cnt2 ? s2[7:0] : lo2_q;
      hi2_d   = cnt2 ? s2[15:8] : hi2_q;
      mode_d  = mode_q;
      ckdiv_d = ckdiv_q;
      rc_d    = rc_q;
      t2c_d   = t2c_q;
      wr      = sfr_req.wr;
      // software writes count bytes, write wins
      if (wr)
      begin
         unique case (sfr_req.addr)
            TMC_ADDR_CNT_LO0:  lo0_d   = sfr_req.wdata;
            TMC_ADDR_CNT_HI0:  hi0_d   = sfr_req.wdata;
            TMC_ADDR_CNT_LO1:  lo1_d   = sfr_req.wdata;
            TMC_ADDR_CNT_HI1:  hi1_d   = sfr_req.wdata;
            TMC_ADDR_CNT_LO2:  lo2_d   = sfr_req.wdata;
            TMC_ADDR_CNT_HI2:  hi2_d   = sfr_req.wdata;
            TMC_ADDR_MODE:     mode_d  = sfr_req.wdata;
            TMC_ADDR_CLK_DIV:  ckdiv_d = sfr_req.wdata;
            TMC_ADDR_RUN_CTRL: rc_d    = sfr_req.wdata;
            TMC_ADDR_T2_CTRL:  t2c_d   = sfr_req.wdata;
            default:           mode_d  = mode_q;
         endcase
      end
      // vector clears flag, overflow set wins
      if (!(wr && sfr_req.addr == TMC_ADDR_RUN_CTRL))
      begin
         rc_d[TMC_OVF0] = rc_q[TMC_OVF0] & ~isr_ack_zero;
         rc_d[TMC_OVF1] = rc_q[TMC_OVF1] & ~isr_ack_one;
      end
      rc_d[TMC_OVF0]  = rc_d[TMC_OVF0] | set0;
      rc_d[TMC_OVF1]  = rc_d[TMC_OVF1] | set1;
      t2c_d[TMC_OVF2] = t2c_d[TMC_OVF2] | set2;
      out0_d = set0;
      out1_d = set1;
      rdata_d = rdata_q;
      if (sfr_req.rd)
      begin
         unique case (sfr_req.addr)
            TMC_ADDR_CNT_LO0:  rdata_d = lo0_q;
            TMC_ADDR_CNT_HI0:  rdata_d = hi0_q;
            TMC_ADDR_CNT_LO1:  rdata_d = lo1_q;
            TMC_ADDR_CNT_HI1:  rdata_d = hi1_q;
            TMC_ADDR_CNT_LO2:  rdata_d = lo2_q;
            TMC_ADDR_CNT_HI2:  rdata_d = hi2_q;
            TMC_ADDR_MODE:     rdata_d = mode_q;
            TMC_ADDR_CLK_DIV:  rdata_d = ckdiv_q;
            TMC_ADDR_RUN_CTRL: rdata_d = rc_q;
            TMC_ADDR_T2_CTRL:  rdata_d = t2c_q;
            default:           rdata_d = TMC_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pins_meta_q <= '0;
         pins_sync_q <= '0;
         pins_prev_q <= '0;
         mode_q      <= TMC_RST_MODE;
         rc_q        <= TMC_RST_RUN_CTRL;
         ckdiv_q     <= TMC_RST_CLK_DIV;
         t2c_q       <= TMC_RST_T2_CTRL;
         lo0_q       <= TMC_RST_CNT;
         hi0_q       <= TMC_RST_CNT;
         lo1_q       <= TMC_RST_CNT;
         hi1_q       <= TMC_RST_CNT;
         lo2_q       <= TMC_RST_CNT;
         hi2_q       <= TMC_RST_CNT;
         pre_q       <= 4'h0;
         out0_q      <= 1'b0;
         out1_q      <= 1'b0;
         rdata_q     <= TMC_UNMAPPED_READ;
      end
      else
      begin
         pins_meta_q <= pins_raw;
         pins_sync_q <= pins_meta_q;
         pins_prev_q <= pins_sync_q[2:0];
         mode_q      <= mode_d;
         rc_q        <= rc_d;
         ckdiv_q     <= ckdiv_d;
         t2c_q       <= t2c_d;
         lo0_q       <= lo0_d;
         hi0_q       <= hi0_d;
         lo1_q       <= lo1_d;
         hi1_q       <= hi1_d;
         lo2_q       <= lo2_d;
         hi2_q       <= hi2_d;
         pre_q       <= pre_d;
         out0_q      <= out0_d;
         out1_q      <= out1_d;
         rdata_q     <= rdata_d;
      end
   end

   assign sfr_rdata          = rdata_q;
   assign timer_out_zero     = out0_q;
   assign timer_out_one      = out1_q;
   assign overflow_flag_zero = rc_q[TMC_OVF0];
   assign overflow_flag_one  = rc_q[TMC_OVF1];
   assign overflow_flag_two  = t2c_q[TMC_OVF2];

   property p_slow_period;
      @(posedge clock) disable iff (!rst_n)
      tick_slow |=> !tick_slow [*8];
   endproperty
   a_slow_period: assert property (p_slow_period)
      else $error("slow divider tick repeats too soon");

   property p_roll13;
      @(posedge clock) disable iff (!rst_n)
      (m0 == TMC_M13 && cnt0 && hi0_q == 8'hFF && lo0_q[4:0] == 5'h1F
       && !wr) |=> (hi0_q == 8'h00 && lo0_q[4:0] == 5'h00
       && overflow_flag_zero && timer_out_zero);
   endproperty
   a_roll13: assert property (p_roll13)
      else $error("13-bit rollover did not wrap and flag");

   property p_pulse_one;
      @(posedge clock) disable iff (!rst_n)
      $rose(timer_out_zero) |=> !timer_out_zero || $past(set0);
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("timer output pulse outlived its overflow");

   property p_ack_clear;
      @(posedge clock) disable iff (!rst_n)
      (isr_ack_one && !set1 && !wr) |=> !overflow_flag_one;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("overflow flag not cleared by vector");

   property p_set_wins;
      @(posedge clock) disable iff (!rst_n)
      set0 |=> overflow_flag_zero;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("overflow lost against clear");

   property p_gate0;
      @(posedge clock) disable iff (!rst_n)
      (mode_q[TMC_GATE0] && !pins_sync_q[TMC_PIN_IRQ0] && !split && !wr)
      |=> $stable(lo0_q) && $stable(hi0_q);
   endproperty
   a_gate0: assert property (p_gate0)
      else $error("timer zero counted with gate pin low");

   property p_run1;
      @(posedge clock) disable iff (!rst_n)
      (!rc_q[TMC_RUN1] && !wr) |=> $stable({hi1_q, lo1_q});
   endproperty
   a_run1: assert property (p_run1)
      else $error("timer one counted while stopped");

   property p_no_split1;
      @(posedge clock) disable iff (!rst_n)
      (m1 == TMC_MSPLIT && !wr) |=> $stable({hi1_q, lo1_q});
   endproperty
   a_no_split1: assert property (p_no_split1)
      else $error("timer one moved in split mode");

   property p_event_once;
      @(posedge clock) disable iff (!rst_n)
      (m0 == TMC_M16 && mode_q[TMC_CT0] && en0 && !wr)
      |=> lo0_q == 8'($past(lo0_q) + ($past(ev_fall[TMC_PIN_EV0]) ? 1 : 0));
   endproperty
   a_event_once: assert property (p_event_once)
      else $error("event count did not track pin edges");

   property p_mode_wr;
      @(posedge clock) disable iff (!rst_n)
      (wr && sfr_req.addr == TMC_ADDR_MODE)
      |=> mode_q == $past(sfr_req.wdata);
   endproperty
   a_mode_wr: assert property (p_mode_wr)
      else $error("mode register write not stored");

endmodule : tmc_timer_counter

// ### tb/tb_top.sv
/*
 tb_top: self-checking bench for the three-channel timer/counter.
 assumes: tmc_pkg compiled first; the design carries its own asserts.
*/
`timescale 1ns/1ps
module tb_top
   import tmc_pkg::*;
;
   // clock, reset and stimulus
   logic         clock;
   logic         rst_n;
   tmc_sfr_req_s req;
   logic         ev0, ev1, ev2, irq0_low, irq1_low, ack0, ack1;
   // observed outputs
   logic [7:0]   rdata;
   logic         tout0, tout1, ovf0, ovf1, ovf2;
   // bookkeeping
   int           num_errors;
   int           samples_checked;
   int           pulses0;
   int           pulses1;
   int           n0, n1, w, w1;
   logic [7:0]   r, d;
   logic [31:0]  seed;
   logic [7:0]   rst_addr [10] = '{8'h88, 8'h89, 8'h8E, 8'h8A, 8'h8B,
                                   8'h8C, 8'h8D, 8'hC8, 8'hCC, 8'hCD};
   logic [7:0]   rst_val  [10] = '{TMC_RST_RUN_CTRL, TMC_RST_MODE,
                                   TMC_RST_CLK_DIV, TMC_RST_CNT,
                                   TMC_RST_CNT, TMC_RST_CNT, TMC_RST_CNT,
                                   TMC_RST_T2_CTRL, TMC_RST_CNT,
                                   TMC_RST_CNT};

   tmc_timer_counter tmc_timer_counter_i (
      .clock                (clock),
      .rst_n                (rst_n),
      .sfr_req              (req),
      .sfr_rdata            (rdata),
      .event_input_zero     (ev0),
      .event_input_one      (ev1),
      .event_input_two      (ev2),
      .ext_irq_pin_zero_low (irq0_low),
      .ext_irq_pin_one_low  (irq1_low),
      .isr_ack_zero         (ack0),
      .isr_ack_one          (ack1),
      .timer_out_zero       (tout0),
      .timer_out_one        (tout1),
      .overflow_flag_zero   (ovf0),
      .overflow_flag_one    (ovf1),
      .overflow_flag_two    (ovf2)
   );

   always #5 clock = ~clock;

   // cycles with each timer output high
   always @(posedge clock)
   begin
      if (tout0 === 1'b1)
         pulses0++;
      if (tout1 === 1'b1)
         pulses1++;
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got,
                  exp);
      end
   endtask : check

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(negedge clock);
      req = '0;
      @(negedge clock);
   endtask : sfr_wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clock);
      req = '0;
      check(rdata, exp);
      @(negedge clock);
   endtask : rd_chk

   // falling edges on an event pin, then settle
   task automatic pulse(input int t, input int n);
      repeat (n)
      begin
         ev0 = (t != 0);
         ev1 = (t != 1);
         ev2 = (t != 2);
         repeat (3) @(negedge clock);
         ev0 = 1'b1;
         ev1 = 1'b1;
         ev2 = 1'b1;
         repeat (3) @(negedge clock);
      end
      repeat (4) @(negedge clock);
   endtask : pulse

   task automatic wait_ovf(input int t, input int maxc, output int n);
      for (n = 0; n < maxc; n++)
      begin
         if ((t == 0 ? ovf0 : ovf1) === 1'b1)
            break;
         @(negedge clock);
      end
   endtask : wait_ovf

   task automatic finish_test;
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   initial
   begin
      #100_000;
      num_errors++;
      finish_test();
   end

   initial
   begin
      clock = 1'b0; rst_n = 1'b0; req = '0; seed = 32'h0000_714C;
      ev0 = 1'b1; ev1 = 1'b1; ev2 = 1'b1; irq0_low = 1'b1;
      irq1_low = 1'b1; ack0 = 1'b0; ack1 = 1'b0;
      num_errors = 0; samples_checked = 0; pulses0 = 0;
      pulses1 = 0;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
      sfr_wr(8'h80, 8'h5A);
      rd_chk(8'h80, TMC_UNMAPPED_READ);
      // random byte writes and readback, timers stopped
      for (int i = 0; i < 5; i++)
      begin
         d = rnd();
         sfr_wr(8'h89 + 8'(i), d);
         rd_chk(8'h89 + 8'(i), d);
      end
      // event counting, timer zero gated, then timer one gated too
      sfr_wr(8'h89, 8'h5D);
      for (int i = 0; i < 4; i++) sfr_wr(8'h8A + 8'(i), 8'h00);
      sfr_wr(8'h88, 8'h50);
      n0 = int'(rnd() % 8) + 1;
      n1 = int'(rnd() % 8) + 1;
      pulse(0, n0);
      pulse(1, n1);
      rd_chk(8'h8A, 8'(n0));
      rd_chk(8'h8B, 8'(n1));
      irq0_low = 1'b0;
      repeat (4) @(negedge clock);
      pulse(0, 3);
      rd_chk(8'h8A, 8'(n0));
      irq0_low = 1'b1;
      sfr_wr(8'h89, 8'hDD);
      irq1_low = 1'b0;
      repeat (4) @(negedge clock);
      pulse(1, 3);
      rd_chk(8'h8B, 8'(n1));
      irq1_low = 1'b1;
      repeat (4) @(negedge clock);
      pulse(1, 2);
      rd_chk(8'h8B, 8'(n1 + 2));
      // 13-bit rollover from 0x1fff
      sfr_wr(8'h88, 8'h00);
      sfr_wr(8'h89, 8'h04);
      sfr_wr(8'h8A, 8'hFF);
      sfr_wr(8'h8C, 8'hFF);
      sfr_wr(8'h88, 8'h10);
      w = pulses0;
      pulse(0, 1);
      check(8'(pulses0 - w), 8'h01);
      check({7'h00, ovf0}, 8'h01);
      rd_chk(8'h8A, 8'hE0);
      rd_chk(8'h8C, 8'h00);
      ack0 = 1'b1;
      @(negedge clock);
      ack0 = 1'b0;
      @(negedge clock);
      check({7'h00, ovf0}, 8'h00);
      // 8-bit auto-reload
      sfr_wr(8'h88, 8'h00);
      r = rnd() & 8'h7F;
      sfr_wr(8'h89, 8'h06);
      sfr_wr(8'h8C, r);
      sfr_wr(8'h8A, 8'hFE);
      sfr_wr(8'h88, 8'h10);
      pulse(0, 3);
      rd_chk(8'h8A, r + 8'h01);
      check({7'h00, ovf0}, 8'h01);
      // split mode: timer one holds
      sfr_wr(8'h88, 8'h00);
      sfr_wr(8'h89, 8'h77);
      sfr_wr(8'h8B, 8'h05);
      sfr_wr(8'h8A, 8'h10);
      sfr_wr(8'h8C, 8'hFF);
      sfr_wr(8'h88, 8'h50);
      pulse(1, 4);
      pulse(0, 2);
      rd_chk(8'h8B, 8'h05);
      rd_chk(8'h8A, 8'h12);
      check({7'h00, ovf1}, 8'h01);
      // divided cpu clock: timer zero by 4, timer one by 12
      sfr_wr(8'h88, 8'h00);
      sfr_wr(8'h89, 8'h11);
      sfr_wr(8'h8E, 8'h08);
      sfr_wr(8'h8A, 8'hFE);
      sfr_wr(8'h8C, 8'hFF);
      sfr_wr(8'h8B, 8'hFD);
      sfr_wr(8'h8D, 8'hFF);
      w1 = pulses1;
      sfr_wr(8'h88, 8'h50);
      wait_ovf(0, 12, w);
      check({7'h00, ovf0}, 8'h01);
      check({7'h00, ovf1}, 8'h00);
      wait_ovf(1, 40, w);
      check({7'h00, ovf1}, 8'h01);
      repeat (2) @(negedge clock);
      check(8'(pulses1 - w1), 8'h01);
      ack1 = 1'b1;
      @(negedge clock);
      ack1 = 1'b0;
      @(negedge clock);
      check({7'h00, ovf1}, 8'h00);
      // timer one: 8-bit reload from the /4 tick
      sfr_wr(8'h88, 8'h00);
      r = rnd();
      sfr_wr(8'h89, 8'h20);
      sfr_wr(8'h8E, 8'h10);
      sfr_wr(8'h8D, r);
      sfr_wr(8'h8B, 8'hFE);
      sfr_wr(8'h88, 8'h40);
      wait_ovf(1, 12, w);
      check({7'h00, ovf1}, 8'h01);
      rd_chk(8'h8B, r);
      // timer two: event count on its own pin
      sfr_wr(8'hCC, 8'hFF);
      sfr_wr(8'hCD, 8'hFF);
      sfr_wr(8'hC8, 8'h06);
      pulse(2, 1);
      check({7'h00, ovf2}, 8'h01);
      rd_chk(8'hCD, 8'h00);
      rd_chk(8'hC8, 8'h86);
      finish_test();
   end
endmodule : tb_top
